/* design/gpm_pkg.sv */
// constants shared by the general purpose port
package gpm_pkg;
  // -----------------------------------------------------------------
  // geometry
  // -----------------------------------------------------------------
  localparam int NUM_PINS = 7;
  localparam int SEL_W = 2;
  localparam int SYNC_SETTLE = 3;

  // -----------------------------------------------------------------
  // per-pin function selection codes
  // -----------------------------------------------------------------
  localparam logic [1:0] SEL_PRIMARY = 2'h0;
  localparam logic [1:0] SEL_ALT1 = 2'h1;
  localparam logic [1:0] SEL_ALT2 = 2'h2;
  localparam logic [1:0] SEL_ALT3 = 2'h3;

  // -----------------------------------------------------------------
  // values after reset
  // -----------------------------------------------------------------
  localparam logic [6:0] PIN_VEC_RST = 7'h00;
  localparam logic [6:0] SYNC_RST = 7'h7f;
  localparam logic [6:0] READ_RST = 7'h7f;
  localparam logic PERIPH_IN_RST = 1'h1;
  localparam logic [1:0] WARM_RST = 2'h0;
  localparam logic [1:0] WARM_MAX = 2'h3;
endpackage : gpm_pkg

/* design/gpm_pad_drv.sv */
// output drive cell of one port pin
module gpm_pad_drv (
  input wire logic val_i,
  input wire logic en_i,
  input wire logic od_i,
  output logic out_o,
  output logic oe_o
);
  // -----------------------------------------------------------------
  // push-pull drives both levels, open drain only pulls low
  // -----------------------------------------------------------------
  always_comb begin
    if (od_i) begin
      out_o = 1'b0;
      oe_o = en_i & ~val_i;
    end else begin
      out_o = val_i;
      oe_o = en_i;
    end
  end
endmodule : gpm_pad_drv

/* design/gpm_port.sv */
// seven-pin general purpose port with alternate function routing

module gpm_port (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [6:0] sw_out_i,
  input wire logic [6:0] sw_oe_i,
  input wire logic [6:0] in_en_i,
  input wire logic [6:0] pu_en_i,
  input wire logic [6:0] pd_en_i,
  input wire logic [6:0] od_en_i,
  input wire logic [13:0] out_sel_i,
  input wire logic [13:0] in_sel_i,
  input wire logic spi_txd_i,
  input wire logic spi_txd_oe_i,
  input wire logic spi_clk_out_i,
  input wire logic spi_clk_out_oe_i,
  input wire logic spi_fs_out_i,
  input wire logic spi_fs_out_oe_i,
  input wire logic dbg_data_out_i,
  input wire logic dbg_data_oe_i,
  input wire logic uart_txd_i,
  input wire logic uart_txd_oe_i,
  input wire logic pwm_i,
  input wire logic pwm_oe_i,
  input wire logic [6:0] pad_in_i,
  output logic [6:0] pad_out_o,
  output logic [6:0] pad_oe_o,
  output logic [6:0] pull_up_o,
  output logic [6:0] pull_dn_o,
  output logic [6:0] sw_in_o,
  output logic spi_rxd_o,
  output logic spi_clock_input_o,
  output logic spi_fs_in_o,
  output logic uart_rxd_o,
  output logic dbg_clk_o,
  output logic dbg_data_in_o
);
  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [6:0] sync1;
    logic [6:0] sync2;
    logic [6:0] pad_out;
    logic [6:0] pad_oe;
    logic [6:0] pull_up;
    logic [6:0] pull_dn;
    logic [6:0] sw_in;
    logic spi_rxd;
    logic spi_clock_input;
    logic spi_fs_in;
    logic uart_rxd;
    logic dbg_clk;
    logic dbg_data_in;
    logic [1:0] warm;
  } gpm_state_t;

  gpm_state_t state_q;
  gpm_state_t state_d;

  // -----------------------------------------------------------------
  // alternate output sources, a value and an enable vector per choice
  // -----------------------------------------------------------------
  logic [6:0] alt1_val;
  logic [6:0] alt1_en;
  logic [6:0] alt2_val;
  logic [6:0] alt2_en;
  logic [6:0] alt3_val;
  logic [6:0] alt3_en;
  logic [6:0] sel_val;
  logic [6:0] sel_en;
  logic [6:0] drv_out;
  logic [6:0] drv_oe;

  // unmapped and reserved slots stay undriven
  assign alt1_val = {dbg_data_out_i, 2'h0, spi_fs_out_i, 1'h0,
                     spi_clk_out_i, spi_txd_i};
  assign alt1_en = {dbg_data_oe_i, 2'h0, spi_fs_out_oe_i, 1'h0,
                    spi_clk_out_oe_i, spi_txd_oe_i};
  assign alt2_val = {4'h0, uart_txd_i, 1'h0, uart_txd_i};
  assign alt2_en = {4'h0, uart_txd_oe_i, 1'h0, uart_txd_oe_i};
  assign alt3_val = {4'h0, pwm_i, pwm_i, pwm_i};
  assign alt3_en = {4'h0, pwm_oe_i, pwm_oe_i, pwm_oe_i};

  // -----------------------------------------------------------------
  // per-pin source mux and drive cell
  // -----------------------------------------------------------------
  // one process drives the whole select vectors
  always_comb begin
    sel_val = '0;
    sel_en = '0;
    for (int k = 0; k < gpm_pkg::NUM_PINS; k++) begin
      unique case (out_sel_i[2*k +: 2])
        gpm_pkg::SEL_ALT1: begin
          sel_val[k] = alt1_val[k];
          sel_en[k] = alt1_en[k];
        end
        gpm_pkg::SEL_ALT2: begin
          sel_val[k] = alt2_val[k];
          sel_en[k] = alt2_en[k];
        end
        gpm_pkg::SEL_ALT3: begin
          sel_val[k] = alt3_val[k];
          sel_en[k] = alt3_en[k];
        end
        gpm_pkg::SEL_PRIMARY: begin
          sel_val[k] = sw_out_i[k];
          sel_en[k] = sw_oe_i[k];
        end
      endcase
    end
  end

  for (genvar k = 0; k < gpm_pkg::NUM_PINS; k++) begin : g_pin
    gpm_pad_drv u_drv (
      .val_i(sel_val[k]),
      .en_i(sel_en[k]),
      .od_i(od_en_i[k]),
      .out_o(drv_out[k]),
      .oe_o(drv_oe[k])
    );
  end

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    logic [6:0] in1;
    logic [6:0] in2;
    in1 = '0;
    in2 = '0;
    state_d = state_q;
    for (int k = 0; k < gpm_pkg::NUM_PINS; k++) begin
      in1[k] = in_en_i[k] && (in_sel_i[2*k +: 2] == gpm_pkg::SEL_ALT1);
      in2[k] = in_en_i[k] && (in_sel_i[2*k +: 2] == gpm_pkg::SEL_ALT2);
    end
    // first stage feeds only the second
    state_d.sync1 = pad_in_i;
    state_d.sync2 = state_q.sync1;
    state_d.pad_out = drv_out;
    state_d.pad_oe = drv_oe;
    state_d.pull_up = pu_en_i;
    state_d.pull_dn = pd_en_i;
    state_d.sw_in = state_q.sync2 | ~in_en_i;
    state_d.spi_rxd = in1[2] ? state_q.sync2[2] : 1'b1;
    state_d.spi_clock_input = in1[4] ? state_q.sync2[4] : 1'b1;
    state_d.spi_fs_in = in1[5] ? state_q.sync2[5] : 1'b1;
    state_d.dbg_data_in = in1[6] ? state_q.sync2[6] : 1'b1;
    state_d.dbg_clk = in2[5] ? state_q.sync2[5] : 1'b1;
    if (in2[0]) begin
      state_d.uart_rxd = state_q.sync2[0];
    end else if (in2[2]) begin
      state_d.uart_rxd = state_q.sync2[2];
    end else begin
      state_d.uart_rxd = 1'b1;
    end
    if (state_q.warm != gpm_pkg::WARM_MAX) begin
      state_d.warm = state_q.warm + 2'h1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q.sync1 <= gpm_pkg::SYNC_RST;
      state_q.sync2 <= gpm_pkg::SYNC_RST;
      state_q.pad_out <= gpm_pkg::PIN_VEC_RST;
      state_q.pad_oe <= gpm_pkg::PIN_VEC_RST;
      state_q.pull_up <= gpm_pkg::PIN_VEC_RST;
      state_q.pull_dn <= gpm_pkg::PIN_VEC_RST;
      state_q.sw_in <= gpm_pkg::READ_RST;
      state_q.spi_rxd <= gpm_pkg::PERIPH_IN_RST;
      state_q.spi_clock_input <= gpm_pkg::PERIPH_IN_RST;
      state_q.spi_fs_in <= gpm_pkg::PERIPH_IN_RST;
      state_q.uart_rxd <= gpm_pkg::PERIPH_IN_RST;
      state_q.dbg_clk <= gpm_pkg::PERIPH_IN_RST;
      state_q.dbg_data_in <= gpm_pkg::PERIPH_IN_RST;
      state_q.warm <= gpm_pkg::WARM_RST;
    end else begin
      state_q <= state_d;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign pad_out_o = state_q.pad_out;
  assign pad_oe_o = state_q.pad_oe;
  assign pull_up_o = state_q.pull_up;
  assign pull_dn_o = state_q.pull_dn;
  assign sw_in_o = state_q.sw_in;
  assign spi_rxd_o = state_q.spi_rxd;
  assign spi_clock_input_o = state_q.spi_clock_input;
  assign spi_fs_in_o = state_q.spi_fs_in;
  assign uart_rxd_o = state_q.uart_rxd;
  assign dbg_clk_o = state_q.dbg_clk;
  assign dbg_data_in_o = state_q.dbg_data_in;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic settled;
  assign settled = (state_q.warm == gpm_pkg::WARM_MAX);

  // first edge after reset still shows reset values, not the inputs
  logic live;
  assign live = (state_q.warm != gpm_pkg::WARM_RST);

  a_read_level: assert property (
    settled |-> sw_in_o == ($past(pad_in_i, 3) | ~$past(in_en_i)))
    else $error("pin read does not follow pin level");

  a_read_disabled: assert property (
    (sw_in_o | $past(in_en_i)) == 7'h7f)
    else $error("disabled input stage did not read high");

  a_primary_drive: assert property (
    (live && $past(out_sel_i[3:2]) == gpm_pkg::SEL_PRIMARY
    && !$past(od_en_i[1]))
    |-> (pad_oe_o[1] == $past(sw_oe_i[1]))
    && (!pad_oe_o[1] || pad_out_o[1] == $past(sw_out_i[1])))
    else $error("pin 1 primary drive mismatch");

  a_od_low_only: assert property (
    (pad_oe_o & $past(od_en_i) & pad_out_o) == 7'h00
    && (pad_oe_o & $past(od_en_i) & $past(sel_val)) == 7'h00)
    else $error("open drain pin driven high");

  a_alt_spi_clk: assert property (
    (live && $past(out_sel_i[3:2]) == gpm_pkg::SEL_ALT1
    && !$past(od_en_i[1]))
    |-> pad_oe_o[1] == $past(spi_clk_out_oe_i)
    && (!pad_oe_o[1] || pad_out_o[1] == $past(spi_clk_out_i)))
    else $error("spi clock not routed to pin 1");

  a_alt_uart_tx: assert property (
    (live && $past(out_sel_i[5:4]) == gpm_pkg::SEL_ALT2
    && !$past(od_en_i[2]))
    |-> pad_oe_o[2] == $past(uart_txd_oe_i)
    && (!pad_oe_o[2] || pad_out_o[2] == $past(uart_txd_i)))
    else $error("uart transmit not routed to pin 2");

  a_reserved_idle: assert property (
    ($past(out_sel_i[7:6]) == gpm_pkg::SEL_ALT2) |-> !pad_oe_o[3])
    else $error("reserved choice drove pin 3");

  a_uart_rx_pin: assert property (
    (settled && $past(in_en_i[0])
    && $past(in_sel_i[1:0]) == gpm_pkg::SEL_ALT2)
    |-> uart_rxd_o == $past(pad_in_i[0], 3))
    else $error("uart receive not taken from pin 0");

  a_spi_spi_clock_input_pin: assert property (
    (settled && $past(in_en_i[4])
    && $past(in_sel_i[9:8]) == gpm_pkg::SEL_ALT1)
    |-> spi_clock_input_o == $past(pad_in_i[4], 3))
    else $error("spi clock input not taken from pin 4");

  a_pull_ctrl: assert property (
    ##1 pull_up_o == $past(pu_en_i) && pull_dn_o == $past(pd_en_i))
    else $error("pull enables do not follow software");

  c_uart_on_pin2: cover property (
    $past(out_sel_i[5:4]) == gpm_pkg::SEL_ALT2 && pad_oe_o[2]);
  c_od_drive_low: cover property (
    $past(od_en_i[0]) && pad_oe_o[0] && !pad_out_o[0]);
  c_spi_spi_clock_input: cover property (
    settled && $past(in_sel_i[9:8]) == gpm_pkg::SEL_ALT1
    && $rose(spi_clock_input_o));
  c_read_low: cover property (settled && !sw_in_o[3]);
endmodule : gpm_port

/* verification/gpm_pin_model.sv */
// wire and external circuitry model for the seven port pins
module gpm_pin_model (
  input wire logic clk_i,
  input wire logic [6:0] pad_out_i,
  input wire logic [6:0] pad_oe_i,
  input wire logic [6:0] pull_up_i,
  input wire logic [6:0] pull_dn_i,
  input wire logic [6:0] ext_en_i,
  input wire logic [6:0] ext_val_i,
  output logic [6:0] pad_in_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] last_q = 7'h00;
  // -----------------------------------------------------------------
  // wire level per pin
  // -----------------------------------------------------------------
  always_comb begin
    for (int k = 0; k < 7; k++) begin
      if (pad_oe_i[k]) pad_in_o[k] = pad_out_i[k];
      else if (ext_en_i[k]) pad_in_o[k] = ext_val_i[k];
      else if (pull_up_i[k] & ~pull_dn_i[k]) pad_in_o[k] = 1'b1;
      else if (pull_dn_i[k] & ~pull_up_i[k]) pad_in_o[k] = 1'b0;
      else pad_in_o[k] = ~last_q[k];
    end
  end
  // floating pin keeps no stable level
  always_ff @(posedge clk_i) last_q <= pad_in_o;
endmodule : gpm_pin_model

/* verification/test_gpm_port.sv */
// self-checking bench for the seven-pin port
module test_gpm_port;
  timeunit 1ns;
  timeprecision 1ns;
  // -----------------------------------------------------------------
  // signals
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [6:0] so, oe, ie, up, dn, od, xe, xv, e_oe, e_out, e_in;
  } gpm_row_t;
  gpm_row_t rows [4] = '{
    {7'h55, 7'h7f, 7'h7f, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00,
     7'h7f, 7'h55, 7'h55},
    {7'h55, 7'h7f, 7'h7f, 7'h7f, 7'h00, 7'h7f, 7'h00, 7'h00,
     7'h2a, 7'h00, 7'h55},
    {7'h7f, 7'h00, 7'h0f, 7'h00, 7'h7f, 7'h00, 7'h00, 7'h00,
     7'h00, 7'h00, 7'h70},
    {7'h00, 7'h00, 7'h7f, 7'h3f, 7'h40, 7'h00, 7'h7f, 7'h2a,
     7'h00, 7'h00, 7'h2a}};
  logic [33:0] irows [7] = '{
    {14'h1510, 7'h2a, 7'h7f, 6'h0e}, {14'h1510, 7'h55, 7'h7f, 6'h37},
    {14'h0802, 7'h55, 7'h7f, 6'h3d}, {14'h0802, 7'h2a, 7'h7f, 6'h3b},
    {14'h0020, 7'h2a, 7'h7f, 6'h3b}, {14'h0022, 7'h04, 7'h7f, 6'h3b},
    {14'h1510, 7'h2a, 7'h00, 6'h3f}};
  gpm_row_t r;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [6:0] sw_out = '0, sw_oe = '0, in_en = '0, pu = '0, pd = '0;
  logic [6:0] od = '0, ext_en = '0, ext = '0;
  logic [13:0] out_sel = '0, in_sel = '0;
  logic [5:0] pv = '0, po = '0;
  wire [5:0] pi;
  logic [6:0] pad_out, pad_oe, pu_o, pd_o, sw_in, pad_in;
  int n_mismatch = 0;
  int n_tests = 0;
  always #5 clk_i = ~clk_i;
  // -----------------------------------------------------------------
  // design and pin model
  // -----------------------------------------------------------------
  gpm_port DUT (
    .clk_i(clk_i), .rst_i(rst_i), .sw_out_i(sw_out), .sw_oe_i(sw_oe),
    .in_en_i(in_en), .pu_en_i(pu), .pd_en_i(pd), .od_en_i(od),
    .out_sel_i(out_sel), .in_sel_i(in_sel),
    .spi_txd_i(pv[5]), .spi_txd_oe_i(po[5]),
    .spi_clk_out_i(pv[4]), .spi_clk_out_oe_i(po[4]),
    .spi_fs_out_i(pv[3]), .spi_fs_out_oe_i(po[3]),
    .dbg_data_out_i(pv[2]), .dbg_data_oe_i(po[2]),
    .uart_txd_i(pv[1]), .uart_txd_oe_i(po[1]),
    .pwm_i(pv[0]), .pwm_oe_i(po[0]), .pad_in_i(pad_in),
    .pad_out_o(pad_out), .pad_oe_o(pad_oe), .pull_up_o(pu_o),
    .pull_dn_o(pd_o), .sw_in_o(sw_in), .spi_rxd_o(pi[5]),
    .spi_clock_input_o(pi[4]), .spi_fs_in_o(pi[3]), .uart_rxd_o(pi[2]),
    .dbg_clk_o(pi[1]), .dbg_data_in_o(pi[0]));
  gpm_pin_model pins (
    .clk_i(clk_i), .pad_out_i(pad_out), .pad_oe_i(pad_oe),
    .pull_up_i(pu_o), .pull_dn_i(pd_o), .ext_en_i(ext_en),
    .ext_val_i(ext), .pad_in_o(pad_in));
  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  task automatic cmp(input logic [6:0] got, input logic [6:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic settle();
    repeat (6) @(negedge clk_i);
  endtask : settle
  // pin vector of an alternate output choice
  function automatic logic [6:0] amap(input int c, input logic [5:0] v);
    case (c)
      1: return {v[2], 2'b00, v[3], 1'b0, v[4], v[5]};
      2: return {4'h0, v[1], 1'b0, v[1]};
      default: return {4'h0, {3{v[0]}}};
    endcase
  endfunction : amap
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  initial begin
    #20us;
    n_mismatch++;
    report_and_stop();
  end
  // -----------------------------------------------------------------
  // tests
  // -----------------------------------------------------------------
  initial begin
    repeat (6) @(negedge clk_i);
    cmp(pad_oe, 7'h00);
    cmp(sw_in, 7'h7f);
    cmp({1'b0, pi}, 7'h3f);
    rst_i = 1'b0;
    $display("reset test done");
    foreach (rows[i]) begin
      r = rows[i];
      {sw_out, sw_oe, in_en, pu, pd, od, ext_en, ext} = r[76:21];
      settle();
      cmp(pad_oe, r.e_oe);
      cmp(pad_out & r.e_oe, r.e_out);
      cmp(sw_in, r.e_in);
      cmp(pu_o, pu);
      cmp(pd_o, pd);
      $display("row %0d done", i);
    end
    {sw_out, sw_oe, in_en, pu, pd, ext_en} = {14'h3fff, 28'h0};
    for (int c = 1; c < 4; c++) begin
      for (int j = 0; j < 3; j++) begin
        out_sel = 14'(c * 14'h1555);
        pv = (j == 1) ? 6'h15 : 6'h2a;
        po = (j == 2) ? 6'h15 : 6'h3f;
        settle();
        cmp(pad_oe, amap(c, po));
        cmp(pad_out & amap(c, po), amap(c, pv) & amap(c, po));
      end
      $display("output choice %0d done", c);
    end
    {out_sel, sw_oe, po, ext_en} = {14'h0, 7'h00, 6'h00, 7'h7f};
    foreach (irows[i]) begin
      {in_sel, ext, in_en} = irows[i][33:6];
      settle();
      cmp({1'b0, pi}, {1'b0, irows[i][5:0]});
      cmp(sw_in, ext | ~in_en);
    end
    $display("input routing done");
    {ext_en, sw_oe, in_en, sw_out} = {7'h00, 7'h7f, 7'h7f, 7'h55};
    settle();
    rst_i = 1'b1;
    #1;
    cmp(pad_oe, 7'h00);
    cmp(sw_in, 7'h7f);
    @(negedge clk_i);
    rst_i = 1'b0;
    settle();
    cmp(pad_oe, 7'h7f);
    cmp(sw_in, 7'h55);
    $display("second reset done");
    report_and_stop();
  end
endmodule : test_gpm_port
